//--- core/ccse_pkg.sv
/*
 * Constants and types shared by the complement and compare-skip executor.
 * Assumes an 8-bit data path, 16-bit program words and a 12-bit data space.
 */
package ccse_pkg;

   localparam int unsigned WORD_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 12;

   // Opcode fields of the two instructions handled here.
   localparam logic [3:0] OPC_TOP_COMPLEMENT = 4'h1;
   localparam logic [1:0] OPC_SUB_COMPLEMENT = 2'h3;
   localparam logic [3:0] OPC_TOP_COMPARE    = 4'h6;
   localparam logic [2:0] OPC_SUB_COMPARE    = 3'h1;

   // Field positions inside the instruction word.
   localparam int unsigned POS_TOP_LSB  = 12;
   localparam int unsigned POS_CSUB_LSB = 10;
   localparam int unsigned POS_QSUB_LSB = 9;
   localparam int unsigned POS_DEST     = 9;
   localparam int unsigned POS_BANK     = 8;

   // Destination bit values.
   localparam logic DEST_ACCUM = 1'b0;
   localparam logic DEST_FILE  = 1'b1;

   // Access bank split and its upper-half page.
   localparam logic [7:0] ILO_LIMIT     = 8'h5F;
   localparam logic [3:0] ACC_LOW_PAGE  = 4'h0;
   localparam logic [3:0] ACC_HIGH_PAGE = 4'hF;

   // Number of program words skipped.
   localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
   localparam logic [1:0] SKIP_TWO_WORD = 2'h2;
   localparam logic [1:0] SKIP_NONE     = 2'h0;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ccse_phase_t;
   typedef enum logic [1:0] {SEQ_EXEC, SEQ_SKIP1, SEQ_SKIP2} ccse_seq_t;
   typedef enum logic [1:0] {OP_NONE, OP_COMPLEMENT, OP_COMPARE} ccse_op_t;

   typedef struct packed {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ccse_dwrite_t;

   typedef struct packed {
      logic we;
      logic neg;
      logic zero;
   } ccse_flags_t;

endpackage

//--- core/ccse_exec.sv
/*
 * Executor for the register-complement and compare-equal-skip instructions.
 * Assumes the fetch unit presents the current word during phase Q1, a data
 * memory that returns read data in the cycle after the address is given,
 * and that the fetch unit flags whether the fetched next word is two-word.
 */
`timescale 1ns/100ps
module ccse_exec (
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        clk_en_i,
   input  wire logic [ccse_pkg::WORD_W-1:0] instr_i,
   input  wire logic                        next_two_word_i,
   input  wire logic [ccse_pkg::DATA_W-1:0] working_accumulator_reg_i,
   input  wire logic [3:0]                  bank_select_register_i,
   input  wire logic [ccse_pkg::ADDR_W-1:0] index_base_i,
   input  wire logic                        ext_set_en_i,
   input  wire logic [ccse_pkg::DATA_W-1:0] dm_rdata_i,
   output logic [1:0]                       phase_o,
   output logic                             dm_rd_o,
   output logic [ccse_pkg::ADDR_W-1:0]      dm_raddr_o,
   output ccse_pkg::ccse_dwrite_t           dm_write_o,
   output logic                             acc_we_o,
   output logic [ccse_pkg::DATA_W-1:0]      acc_wdata_o,
   output ccse_pkg::ccse_flags_t            flags_o,
   output logic                             discard_o,
   output logic [1:0]                       skip_words_o,
   output logic                             nop_cycle_o
);
   import ccse_pkg::*;

   ccse_phase_t       phase_q;
   ccse_seq_t         seq_q;
   ccse_op_t          op_q;
   logic              dest_q;
   logic              two_word_q;
   logic [ADDR_W-1:0] addr_q;
   ccse_op_t          op_d;
   logic [ADDR_W-1:0] addr_d;
   logic [7:0]        file_f;
   logic              bank_a;
   logic [DATA_W-1:0] inv_data;
   logic [DATA_W-1:0] diff;

   assign file_f   = instr_i[POS_BANK-1:0];
   assign bank_a   = instr_i[POS_BANK];
   assign inv_data = ~dm_rdata_i;
   assign diff     = dm_rdata_i - working_accumulator_reg_i;

   // Opcode match; anything else is left to the rest of the core.
   always_comb begin
      op_d = OP_NONE;
      if (instr_i[WORD_W-1:POS_TOP_LSB] == OPC_TOP_COMPLEMENT &&
          instr_i[POS_TOP_LSB-1:POS_CSUB_LSB] == OPC_SUB_COMPLEMENT) begin
         op_d = OP_COMPLEMENT;
      end else if (instr_i[WORD_W-1:POS_TOP_LSB] == OPC_TOP_COMPARE &&
          instr_i[POS_TOP_LSB-1:POS_QSUB_LSB] == OPC_SUB_COMPARE) begin
         op_d = OP_COMPARE;
      end
   end

   // Data address formation; the indexed mode needs the extended set.
   always_comb begin
      if (bank_a) begin
         addr_d = {bank_select_register_i, file_f};
      end else if (ext_set_en_i && file_f <= ILO_LIMIT) begin
         addr_d = index_base_i + {{(ADDR_W-8){1'b0}}, file_f};
      end else if (file_f <= ILO_LIMIT) begin
         addr_d = {ACC_LOW_PAGE, file_f};
      end else begin
         addr_d = {ACC_HIGH_PAGE, file_f};
      end
   end

   // Free-running four-phase sequencer.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         phase_q <= PH_Q1;
      end else if (clk_en_i) begin
         case (phase_q)
            PH_Q1:   phase_q <= PH_Q2;
            PH_Q2:   phase_q <= PH_Q3;
            PH_Q3:   phase_q <= PH_Q4;
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   // Decode in Q1; skip cycles decode nothing so the word is thrown away.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         op_q   <= OP_NONE;
         dest_q <= DEST_FILE;
         addr_q <= '0;
      end else if (clk_en_i && phase_q == PH_Q1) begin
         op_q   <= (seq_q == SEQ_EXEC) ? op_d : OP_NONE;
         dest_q <= instr_i[POS_DEST];
         addr_q <= addr_d;
      end
   end

   // Read strobe is held through Q2 only.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         dm_rd_o    <= 1'b0;
         dm_raddr_o <= '0;
      end else if (clk_en_i) begin
         dm_rd_o <= phase_q == PH_Q1 && seq_q == SEQ_EXEC &&
                    op_d != OP_NONE;
         if (phase_q == PH_Q1) begin
            dm_raddr_o <= addr_d;
         end
      end
   end

   // Process in Q3, results land on the ports for the Q4 cycle.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         dm_write_o  <= '0;
         acc_we_o    <= 1'b0;
         acc_wdata_o <= '0;
         flags_o     <= '0;
      end else if (clk_en_i) begin
         dm_write_o.en <= 1'b0;
         acc_we_o      <= 1'b0;
         flags_o.we    <= 1'b0;
         if (phase_q == PH_Q3 && op_q == OP_COMPLEMENT) begin
            dm_write_o.en   <= dest_q == DEST_FILE;
            dm_write_o.addr <= addr_q;
            dm_write_o.data <= inv_data;
            acc_we_o        <= dest_q == DEST_ACCUM;
            acc_wdata_o     <= inv_data;
            flags_o.we      <= 1'b1;
            flags_o.neg     <= inv_data[DATA_W-1];
            flags_o.zero    <= inv_data == '0;
         end
      end
   end

   // Skip control: the discard and counter step are shown during Q4.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         discard_o    <= 1'b0;
         skip_words_o <= SKIP_NONE;
      end else if (clk_en_i) begin
         discard_o    <= 1'b0;
         skip_words_o <= SKIP_NONE;
         if (phase_q == PH_Q3 && op_q == OP_COMPARE &&
             diff == '0) begin
            discard_o    <= 1'b1;
            skip_words_o <= next_two_word_i ? SKIP_TWO_WORD
                                            : SKIP_ONE_WORD;
         end
      end
   end

   // Skip sequence; a two-word victim costs a second idle cycle.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         seq_q      <= SEQ_EXEC;
         two_word_q <= 1'b0;
      end else if (clk_en_i && phase_q == PH_Q4) begin
         case (seq_q)
            SEQ_EXEC: begin
               if (discard_o) begin
                  seq_q      <= SEQ_SKIP1;
                  two_word_q <= skip_words_o == SKIP_TWO_WORD;
               end
            end
            SEQ_SKIP1: begin
               seq_q <= two_word_q ? SEQ_SKIP2 : SEQ_EXEC;
            end
            default: seq_q <= SEQ_EXEC;
         endcase
      end
   end

   // Phase and idle-cycle indication for the rest of the core.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         phase_o     <= PH_Q1;
         nop_cycle_o <= 1'b0;
      end else if (clk_en_i) begin
         phase_o <= (phase_q == PH_Q4) ? PH_Q1 : phase_q + 2'h1;
         if (phase_q == PH_Q4) begin
            nop_cycle_o <= (seq_q == SEQ_EXEC && discard_o) ||
                           (seq_q == SEQ_SKIP1 && two_word_q);
         end
      end
   end

   // Assertions; a frozen clock enable must never fake a process step.
   sequence s_cmp_hit;
      phase_q == PH_Q3 && op_q == OP_COMPARE && diff == '0 && clk_en_i;
   endsequence

   sequence s_compl_proc;
      phase_q == PH_Q3 && op_q == OP_COMPLEMENT && clk_en_i;
   endsequence

   a_read_in_q2: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      dm_rd_o |-> phase_q == PH_Q2)
      else $error("Read strobe outside Q2");
   a_write_in_q4: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (dm_write_o.en || acc_we_o) |-> phase_q == PH_Q4)
      else $error("Result write outside Q4");
   a_compl_inverse: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_compl_proc |=> flags_o.we && acc_wdata_o == ~$past(dm_rdata_i) &&
      flags_o.neg == acc_wdata_o[DATA_W-1] &&
      flags_o.zero == (acc_wdata_o == '0))
      else $error("Complement result or flags wrong");
   a_dest_select: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_compl_proc |=>
      acc_we_o == !$past(dest_q) && dm_write_o.en == $past(dest_q))
      else $error("Complement destination wrong");
   a_cmp_no_flags: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (phase_q == PH_Q3 && op_q == OP_COMPARE && clk_en_i) |=>
      !flags_o.we && !acc_we_o && !dm_write_o.en)
      else $error("Compare touched flags or data");
   a_cmp_decode: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (phase_q == PH_Q1 && clk_en_i && seq_q == SEQ_EXEC &&
       instr_i[15:9] == 7'h31) |=> op_q == OP_COMPARE)
      else $error("Compare opcode not decoded");
   a_skip_discard: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_cmp_hit |=> discard_o && skip_words_o != SKIP_NONE)
      else $error("Equal compare did not discard");
   a_skip_two_word: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      s_cmp_hit ##0 next_two_word_i |=> skip_words_o == SKIP_TWO_WORD)
      else $error("Two-word skip count wrong");
   a_skip_nop: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      seq_q != SEQ_EXEC |-> !dm_rd_o && !dm_write_o.en && !acc_we_o)
      else $error("Activity during skip cycle");
   a_nop_marks: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      nop_cycle_o == (seq_q != SEQ_EXEC))
      else $error("Idle-cycle marker disagrees with skip state");
   a_bank_addr: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (phase_q == PH_Q1 && clk_en_i && bank_a) |=>
      dm_raddr_o == {$past(bank_select_register_i), $past(file_f)})
      else $error("Banked address wrong");
   a_index_addr: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      (phase_q == PH_Q1 && clk_en_i && !bank_a && ext_set_en_i &&
       file_f <= ILO_LIMIT) |=> dm_raddr_o ==
      $past(index_base_i) + {4'h0, $past(file_f)})
      else $error("Indexed address wrong");

endmodule

//--- verification/ccse_tb.sv
/*
 * Self-checking bench for the complement and compare-skip executor.
 * Assumes ccse_exec and ccse_pkg are compiled first and one core clock.
 */
`timescale 1ns/100ps
module tb;
   import ccse_pkg::*;
   logic                core_clk_i = 1'b0;
   logic                rst_b_i;
   logic                clk_en_i;
   logic [WORD_W-1:0]   instr_i;
   logic                next_two_word_i;
   logic [DATA_W-1:0]   acc_i;
   logic [3:0]          bank_i;
   logic [ADDR_W-1:0]   base_i;
   logic                ext_i;
   logic [DATA_W-1:0]   rdata_i;
   logic [1:0]          phase_o;
   logic                dm_rd_o;
   logic [ADDR_W-1:0]   dm_raddr_o;
   ccse_dwrite_t        dm_write_o;
   logic                acc_we_o;
   logic [DATA_W-1:0]   acc_wdata_o;
   ccse_flags_t         flags_o;
   logic                discard_o;
   logic [1:0]          skip_words_o;
   logic                nop_cycle_o;
   int                  err_total = 0;
   int                  n_compared = 0;
   int                  cycles = 0;
   logic [31:0]         seed = 32'h62101A73;
   logic [7:0]          last_q = 8'h00;
   wire  [4:0]          pulse_w = {dm_rd_o, dm_write_o.en, acc_we_o,
                                   flags_o.we, discard_o};

   // The 40 MHz core clock.
   always #12.5 core_clk_i = ~core_clk_i;

   ccse_exec dut (
      .core_clk_i                (core_clk_i),
      .rst_b_i                   (rst_b_i),
      .clk_en_i                  (clk_en_i),
      .instr_i                   (instr_i),
      .next_two_word_i           (next_two_word_i),
      .working_accumulator_reg_i (acc_i),
      .bank_select_register_i    (bank_i),
      .index_base_i              (base_i),
      .ext_set_en_i              (ext_i),
      .dm_rdata_i                (rdata_i),
      .phase_o                   (phase_o),
      .dm_rd_o                   (dm_rd_o),
      .dm_raddr_o                (dm_raddr_o),
      .dm_write_o                (dm_write_o),
      .acc_we_o                  (acc_we_o),
      .acc_wdata_o               (acc_wdata_o),
      .flags_o                   (flags_o),
      .discard_o                 (discard_o),
      .skip_words_o              (skip_words_o),
      .nop_cycle_o               (nop_cycle_o)
   );

   // Xorshift source, so every run repeats the same stimulus.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // A hang ends the run well after the longest expected sequence.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         $display("Error at %0t: timeout", $time);
         end_sim();
      end
   end

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pulse(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: phase/strobes %b, expected %b",
                  $time, got, exp);
      end
   endtask

   // One enabled edge, sometimes preceded by a frozen edge that must hold.
   task automatic tick(input logic [1:0] ph, input logic [4:0] p,
                       input logic nop);
      if (rnd() % 8 == 0) begin
         clk_en_i = 1'b0;
         @(posedge core_clk_i);
         @(negedge core_clk_i);
         chk_pulse({phase_o, nop_cycle_o, pulse_w}, last_q);
         clk_en_i = 1'b1;
      end
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      last_q = {ph, nop, p};
      chk_pulse({phase_o, nop_cycle_o, pulse_w}, last_q);
   endtask

   // Runs one instruction cycle plus any skip cycles against the model.
   task automatic run(input logic [15:0] w, input logic [7:0] r,
                      input logic [7:0] a_v, input logic two);
      logic        cm;
      logic        cp;
      logic        hit;
      logic [11:0] ad;
      logic [7:0]  res;
      logic [4:0]  q4;
      int          n;
      cm = (w[15:12] == 4'h1) && (w[11:10] == 2'h3);
      cp = (w[15:12] == 4'h6) && (w[11:9] == 3'h1);
      hit = cp && (r == a_v);
      res = ~r;
      n = hit ? (two ? 8 : 4) : 0;
      if (w[8]) ad = {bank_i, w[7:0]};
      else if (w[7:0] > 8'h5F) ad = {4'hF, w[7:0]};
      else if (ext_i) ad = base_i + 12'(w[7:0]);
      else ad = 12'(w[7:0]);
      q4 = cm ? {1'b0, w[9], ~w[9], 2'b10} : {4'h0, hit};
      instr_i = w;
      rdata_i = ~r;
      acc_i = ~a_v;
      tick(2'h1, (cm | cp) ? 5'h10 : 5'h00, 1'b0);
      if (cm | cp) chk_data(32'(dm_raddr_o), 32'(ad));
      instr_i = 16'(rnd());
      rdata_i = r;
      acc_i = a_v;
      next_two_word_i = two;
      tick(2'h2, 5'h00, 1'b0);
      tick(2'h3, q4, 1'b0);
      if (cm) chk_data(32'({flags_o.neg, flags_o.zero}),
                       32'({res[7], res == 8'h00}));
      if (cm & w[9]) begin
         chk_data(32'({dm_write_o.addr, dm_write_o.data}),
                  32'({ad, res}));
      end
      if (cm & ~w[9]) chk_data(32'(acc_wdata_o), 32'(res));
      chk_data(32'(skip_words_o), 32'(n / 4));
      instr_i = {6'h07, 10'(rnd())};
      tick(2'h0, 5'h00, hit);
      for (int k = 1; k <= n; k++) begin
         tick(2'(k % 4), 5'h00, k < n);
      end
   endtask

   // Reset, directed cases, then randomised traffic.
   initial begin
      logic [15:0] w;
      logic [7:0]  r;
      logic [7:0]  a;
      rst_b_i = 1'b0;
      clk_en_i = 1'b1;
      instr_i = '0;
      next_two_word_i = 1'b0;
      acc_i = '0;
      bank_i = 4'h0;
      base_i = '0;
      ext_i = 1'b0;
      rdata_i = '0;
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk_pulse({phase_o, nop_cycle_o, pulse_w}, 8'h00);
      rst_b_i = 1'b1;
      run(16'h1C20, 8'h13, 8'h00, 1'b0);
      bank_i = 4'h5;
      run(16'h1F80, 8'hFF, 8'h00, 1'b0);
      $display("Test complement finished at %0t", $time);
      ext_i = 1'b1;
      base_i = 12'h300;
      run(16'h625F, 8'h7A, 8'h7A, 1'b0);
      run(16'h6260, 8'h80, 8'h80, 1'b1);
      run(16'h6301, 8'h01, 8'h02, 1'b1);
      run(16'h6400, 8'h00, 8'h00, 1'b0);
      $display("Test compare finished at %0t", $time);
      for (int i = 0; i < 60; i++) begin
         bank_i = 4'(rnd());
         base_i = 12'(rnd());
         ext_i = 1'(rnd());
         w = 16'(rnd());
         case (rnd() % 3)
            0: w[15:10] = 6'h07;
            1: w[15:9] = 7'h31;
            default: ;
         endcase
         r = 8'(rnd());
         a = (rnd() % 2 == 0) ? r : 8'(rnd());
         run(w, r, a, 1'(rnd()));
      end
      $display("Test random finished at %0t", $time);
      end_sim();
   end
endmodule
